// ---- inc/sdr_pkg.sv ----
// Purpose: shared constants and types of the shift and digit rotate unit
// Assumes: byte-wide external memory with 16-bit addresses, APB register access
// Notes: T-state lists are packed, element 0 being the first machine cycle
package sdr_pkg;
	localparam int unsigned CLK_HZ     = 125_000_000;
	localparam int unsigned TSTATE_HZ  = 4_000_000;
	// Longest T-state that fits the clock: rounded down
	localparam int unsigned TSTATE_DIV = CLK_HZ / TSTATE_HZ;

	localparam logic [7:0] OFS_INSTR  = 8'h00;
	localparam logic [7:0] OFS_STATUS = 8'h04;
	localparam logic [7:0] OFS_AF     = 8'h08;
	localparam logic [7:0] OFS_BCDE   = 8'h0c;
	localparam logic [7:0] OFS_HL     = 8'h10;
	localparam logic [7:0] OFS_INDEX  = 8'h14;

	localparam int STS_BUSY = 0;
	localparam int STS_DONE = 1;
	localparam int STS_BAD  = 2;

	localparam int FLG_S = 7;
	localparam int FLG_Z = 6;
	localparam int FLG_H = 4;
	localparam int FLG_P = 2;
	localparam int FLG_N = 1;
	localparam int FLG_C = 0;

	localparam logic [7:0] PFX_CB      = 8'hcb;
	localparam logic [7:0] PFX_IDX1    = 8'hdd;
	localparam logic [7:0] PFX_IDX2    = 8'hfd;
	localparam logic [7:0] PFX_ED      = 8'hed;
	localparam logic [7:0] OPC_ASR_MEM = 8'h2e;
	localparam logic [7:0] OPC_LSR_MEM = 8'h3e;
	localparam logic [7:0] OPC_DRL     = 8'h6f;
	localparam logic [7:0] OPC_DRR     = 8'h67;
	localparam logic [4:0] ASR_HI      = 5'h05;
	localparam logic [4:0] LSR_HI      = 5'h07;

	localparam logic [2:0] RC_B   = 3'h0;
	localparam logic [2:0] RC_C   = 3'h1;
	localparam logic [2:0] RC_D   = 3'h2;
	localparam logic [2:0] RC_E   = 3'h3;
	localparam logic [2:0] RC_H   = 3'h4;
	localparam logic [2:0] RC_L   = 3'h5;
	localparam logic [2:0] RC_MEM = 3'h6;
	localparam logic [2:0] RC_A   = 3'h7;

	localparam logic [2:0] MC_REG = 3'h2;
	localparam logic [2:0] MC_PTR = 3'h4;
	localparam logic [2:0] MC_IDX = 3'h6;
	localparam logic [2:0] MC_DIG = 3'h5;
	localparam logic [5:0][2:0] TS_REG = {3'h0, 3'h0, 3'h0, 3'h0, 3'h4, 3'h4};
	localparam logic [5:0][2:0] TS_PTR = {3'h0, 3'h0, 3'h3, 3'h4, 3'h4, 3'h4};
	localparam logic [5:0][2:0] TS_IDX = {3'h3, 3'h4, 3'h5, 3'h3, 3'h4, 3'h4};
	localparam logic [5:0][2:0] TS_DIG = {3'h0, 3'h3, 3'h4, 3'h3, 3'h4, 3'h4};
	localparam logic [4:0] TT_REG = 5'h08;
	localparam logic [4:0] TT_PTR = 5'h0f;
	localparam logic [4:0] TT_IDX = 5'h17;
	localparam logic [4:0] TT_DIG = 5'h12;
	localparam logic [2:0] RD_PTR = 3'h2;
	localparam logic [2:0] WR_PTR = 3'h3;
	localparam logic [2:0] RD_IDX = 3'h4;
	localparam logic [2:0] WR_IDX = 3'h5;
	localparam logic [2:0] RD_DIG = 3'h2;
	localparam logic [2:0] WR_DIG = 3'h4;

	localparam logic [7:0]  RST_BYTE = 8'h00;
	localparam logic [15:0] RST_WORD = 16'h0000;

	typedef enum logic [3:0] {
		OP_ASR = 4'h1, OP_LSR = 4'h2, OP_DRL = 4'h4, OP_DRR = 4'h8
	} sdr_op_e;
	typedef enum logic [4:0] {
		FM_NONE = 5'h01, FM_REG = 5'h02, FM_PTR = 5'h04, FM_IDX = 5'h08, FM_DIG = 5'h10
	} sdr_form_e;
	typedef enum logic [1:0] {ST_IDLE = 2'h1, ST_RUN = 2'h2} sdr_fsm_e;

	typedef struct packed {
		sdr_form_e form;
		sdr_op_e   op;
	} sdr_dec_s;

	typedef struct packed {
		logic [15:0] addr;
		logic [7:0]  wdata;
		logic        rd;
		logic        wr;
	} sdr_mem_s;
endpackage

// ---- core/sdr_tick.sv ----
// Purpose: T-state enable pulse divider
// Assumes: DIV of one or more clock cycles per T-state
// Notes: restart aligns the first pulse to a full period after a start
`timescale 1ns/100ps
module sdr_tick #(
	parameter int unsigned DIV = sdr_pkg::TSTATE_DIV
) (
	input  wire logic clock_in,   // Core clock
	input  wire logic arst_n_in,  // Asynchronous reset, active low
	input  wire logic restart_in, // Clear the divider
	output logic      tick_out    // One-cycle T-state pulse
);
	localparam int W = (DIV > 1) ? $clog2(DIV) : 1;
	typedef struct packed {
		logic [W-1:0] count;
	} sdr_tick_s;

	sdr_tick_s st;
	sdr_tick_s next_st;

	always_comb begin
		next_st = st;
		if (restart_in || st.count == W'(DIV - 1)) begin
			next_st.count = '0;
		end else begin
			next_st.count = st.count + W'(1);
		end
	end

	assign tick_out = (st.count == W'(DIV - 1)) && !restart_in;

	always_ff @(posedge clock_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end
endmodule

// ---- core/sdr_alu.sv ----
// Purpose: shift and digit rotate result and flag logic
// Assumes: purely combinational, called once per operand
// Notes: undocumented flag bits 5 and 3 pass through unchanged
`timescale 1ns/100ps
module sdr_alu (
	input  wire sdr_pkg::sdr_op_e op_in,     // Operation
	input  wire logic [7:0]       opnd_in,   // Register or memory operand
	input  wire logic [7:0]       acc_in,    // Accumulator before
	input  wire logic [7:0]       flags_in,  // Flags before
	output logic [7:0]            res_out,   // Operand result
	output logic [7:0]            acc_out,   // Accumulator after
	output logic [7:0]            flags_out  // Flags after
);
	logic [7:0] src;

	always_comb begin
		res_out   = opnd_in;
		acc_out   = acc_in;
		flags_out = flags_in;
		case (op_in)
			sdr_pkg::OP_ASR: begin
				res_out = {opnd_in[7], opnd_in[7:1]};
				flags_out[sdr_pkg::FLG_C] = opnd_in[0];
			end
			sdr_pkg::OP_LSR: begin
				res_out = {1'b0, opnd_in[7:1]};
				flags_out[sdr_pkg::FLG_C] = opnd_in[0];
			end
			sdr_pkg::OP_DRL: begin
				res_out = {opnd_in[3:0], acc_in[3:0]};
				acc_out = {acc_in[7:4], opnd_in[7:4]};
			end
			sdr_pkg::OP_DRR: begin
				res_out = {acc_in[3:0], opnd_in[7:4]};
				acc_out = {acc_in[7:4], opnd_in[3:0]};
			end
			default: begin
				res_out = opnd_in;
			end
		endcase
		// Shifts judge the result, digit rotates the accumulator; carry kept on rotates
		src = (op_in == sdr_pkg::OP_DRL || op_in == sdr_pkg::OP_DRR) ? acc_out : res_out;
		flags_out[sdr_pkg::FLG_S] = src[7];
		flags_out[sdr_pkg::FLG_Z] = (src == 8'h00);
		flags_out[sdr_pkg::FLG_H] = 1'b0;
		flags_out[sdr_pkg::FLG_P] = ~^src;
		flags_out[sdr_pkg::FLG_N] = 1'b0;
	end
endmodule

// ---- core/sdr_core.sv ----
// Purpose: execution unit for right shifts and digit rotates, APB slave
// Assumes: memory read data valid on the last clock of a read machine cycle
// Notes: instruction bytes are written as one word, first byte in bits 7:0
`timescale 1ns/100ps
module sdr_core #(
	parameter int unsigned TSTATE_DIV = sdr_pkg::TSTATE_DIV
) (
	input  wire logic             clock_in,     // 125 MHz core clock
	input  wire logic             arst_n_in,    // Asynchronous reset, active low
	input  wire logic             psel_in,      // APB select
	input  wire logic             penable_in,   // APB enable
	input  wire logic             pwrite_in,    // APB write
	input  wire logic [7:0]       paddr_in,     // APB byte address
	input  wire logic [31:0]      pwdata_in,    // APB write data
	input  wire logic [3:0]       pstrb_in,     // APB byte strobes
	output logic [31:0]           prdata_out,   // APB read data
	output logic                  pready_out,   // APB ready
	output logic                  pslverr_out,  // APB error
	input  wire logic [7:0]       mem_rdata_in, // Memory read data
	output sdr_pkg::sdr_mem_s     mem_out,      // Memory address, data, strobes
	output logic                  busy_out      // Instruction running
);
	typedef struct packed {
		sdr_pkg::sdr_fsm_e  fsm;
		sdr_pkg::sdr_form_e form;
		sdr_pkg::sdr_op_e   op;
		logic [31:0]        instr;
		logic [2:0]         mcyc;
		logic [2:0]         tcnt;
		logic [4:0]         tsum;
		logic [7:0]         a;
		logic [7:0]         f;
		logic [7:0]         b;
		logic [7:0]         c;
		logic [7:0]         d;
		logic [7:0]         e;
		logic [7:0]         h;
		logic [7:0]         l;
		logic [15:0]        ix;
		logic [15:0]        iy;
		logic [7:0]         opnd;
		logic [15:0]        mem_addr;
		logic [7:0]         mem_wdata;
		logic               done;
		logic               bad;
		logic [31:0]        prdata;
		logic               pslverr;
	} sdr_core_s;

	sdr_core_s           st;
	sdr_core_s           next_st;
	sdr_pkg::sdr_dec_s   dec;
	logic                tick;
	logic                start;
	logic                run;
	logic                mem_form;
	logic                in_rd;
	logic                m_end;
	logic                last_m;
	logic [2:0]          len;
	logic [2:0]          rd_idx;
	logic [2:0]          wr_idx;
	logic [2:0]          rcode;
	logic [7:0]          alu_opnd;
	logic [7:0]          alu_res;
	logic [7:0]          alu_acc;
	logic [7:0]          alu_flags;
	logic                setup;
	logic                wr_acc;
	logic [31:0]         wmerge;

	function automatic sdr_pkg::sdr_dec_s decode(input logic [31:0] w);
		sdr_pkg::sdr_dec_s r;
		r.form = sdr_pkg::FM_NONE;
		r.op   = sdr_pkg::OP_ASR;
		if (w[7:0] == sdr_pkg::PFX_CB) begin
			if (w[15:11] == sdr_pkg::ASR_HI || w[15:11] == sdr_pkg::LSR_HI) begin
				r.op   = (w[15:11] == sdr_pkg::ASR_HI) ? sdr_pkg::OP_ASR : sdr_pkg::OP_LSR;
				// Code 110 selects the pointed byte, not a register
				r.form = (w[10:8] == sdr_pkg::RC_MEM) ? sdr_pkg::FM_PTR : sdr_pkg::FM_REG;
			end
		end else if ((w[7:0] == sdr_pkg::PFX_IDX1 || w[7:0] == sdr_pkg::PFX_IDX2) &&
				w[15:8] == sdr_pkg::PFX_CB) begin
			if (w[31:24] == sdr_pkg::OPC_ASR_MEM || w[31:24] == sdr_pkg::OPC_LSR_MEM) begin
				r.op   = (w[31:24] == sdr_pkg::OPC_ASR_MEM) ? sdr_pkg::OP_ASR
					: sdr_pkg::OP_LSR;
				r.form = sdr_pkg::FM_IDX;
			end
		end else if (w[7:0] == sdr_pkg::PFX_ED) begin
			if (w[15:8] == sdr_pkg::OPC_DRL || w[15:8] == sdr_pkg::OPC_DRR) begin
				r.op   = (w[15:8] == sdr_pkg::OPC_DRL) ? sdr_pkg::OP_DRL : sdr_pkg::OP_DRR;
				r.form = sdr_pkg::FM_DIG;
			end
		end
		return r;
	endfunction

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
			input logic [3:0] strb);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				r[8*i +: 8] = nw[8*i +: 8];
			end
		end
		return r;
	endfunction

	function automatic logic [7:0] reg_read(input sdr_core_s s, input logic [2:0] code);
		logic [7:0] r;
		case (code)
			sdr_pkg::RC_B: r = s.b;
			sdr_pkg::RC_C: r = s.c;
			sdr_pkg::RC_D: r = s.d;
			sdr_pkg::RC_E: r = s.e;
			sdr_pkg::RC_H: r = s.h;
			sdr_pkg::RC_L: r = s.l;
			sdr_pkg::RC_A: r = s.a;
			default:       r = sdr_pkg::RST_BYTE;
		endcase
		return r;
	endfunction

	sdr_tick #(
		.DIV (TSTATE_DIV)
	) u_tick (
		.clock_in   (clock_in),
		.arst_n_in  (arst_n_in),
		.restart_in (start),
		.tick_out   (tick)
	);

	sdr_alu u_alu (
		.op_in     (st.op),
		.opnd_in   (alu_opnd),
		.acc_in    (st.a),
		.flags_in  (st.f),
		.res_out   (alu_res),
		.acc_out   (alu_acc),
		.flags_out (alu_flags)
	);

	always_comb begin
		len    = 3'h0;
		rd_idx = 3'h7;
		wr_idx = 3'h7;
		last_m = 1'b0;
		case (st.form)
			sdr_pkg::FM_REG: begin
				len    = sdr_pkg::TS_REG[st.mcyc];
				last_m = (st.mcyc == sdr_pkg::MC_REG - 3'h1);
			end
			sdr_pkg::FM_PTR: begin
				len    = sdr_pkg::TS_PTR[st.mcyc];
				last_m = (st.mcyc == sdr_pkg::MC_PTR - 3'h1);
				rd_idx = sdr_pkg::RD_PTR;
				wr_idx = sdr_pkg::WR_PTR;
			end
			sdr_pkg::FM_IDX: begin
				len    = sdr_pkg::TS_IDX[st.mcyc];
				last_m = (st.mcyc == sdr_pkg::MC_IDX - 3'h1);
				rd_idx = sdr_pkg::RD_IDX;
				wr_idx = sdr_pkg::WR_IDX;
			end
			sdr_pkg::FM_DIG: begin
				len    = sdr_pkg::TS_DIG[st.mcyc];
				last_m = (st.mcyc == sdr_pkg::MC_DIG - 3'h1);
				rd_idx = sdr_pkg::RD_DIG;
				wr_idx = sdr_pkg::WR_DIG;
			end
			default: begin
				len = 3'h0;
			end
		endcase
	end

	assign run      = (st.fsm == sdr_pkg::ST_RUN);
	assign mem_form = (st.form != sdr_pkg::FM_REG);
	assign in_rd    = run && mem_form && (st.mcyc == rd_idx);
	assign m_end    = run && tick && (st.tcnt == len - 3'h1);
	assign rcode    = st.instr[10:8];
	assign alu_opnd = !mem_form ? reg_read(st, rcode) : (in_rd ? mem_rdata_in : st.opnd);
	assign setup    = psel_in && !penable_in;
	assign wr_acc   = psel_in && penable_in && pwrite_in && !st.pslverr;
	assign wmerge   = merge(st.instr, pwdata_in, pstrb_in);
	assign dec      = decode(wmerge);
	assign start    = wr_acc && paddr_in == sdr_pkg::OFS_INSTR && dec.form != sdr_pkg::FM_NONE;

	always_comb begin
		logic [31:0] w;
		w       = '0;
		next_st = st;
		// Read data and error are latched in the setup cycle so that they come from flops
		if (setup) begin
			next_st.pslverr = !run ? 1'b0 : (pwrite_in && paddr_in != sdr_pkg::OFS_STATUS);
			case (paddr_in)
				sdr_pkg::OFS_INSTR:  next_st.prdata = st.instr;
				sdr_pkg::OFS_STATUS: next_st.prdata = {29'h0, st.bad, st.done, run};
				sdr_pkg::OFS_AF:     next_st.prdata = {16'h0, st.a, st.f};
				sdr_pkg::OFS_BCDE:   next_st.prdata = {st.b, st.c, st.d, st.e};
				sdr_pkg::OFS_HL:     next_st.prdata = {16'h0, st.h, st.l};
				sdr_pkg::OFS_INDEX:  next_st.prdata = {st.ix, st.iy};
				default: begin
					next_st.prdata  = 32'h0;
					next_st.pslverr = 1'b1;
				end
			endcase
		end
		if (wr_acc) begin
			case (paddr_in)
				sdr_pkg::OFS_INSTR: begin
					next_st.instr = wmerge;
					next_st.bad   = dec.form == sdr_pkg::FM_NONE;
				end
				sdr_pkg::OFS_STATUS: begin
					if (pstrb_in[0] && pwdata_in[sdr_pkg::STS_DONE]) next_st.done = 1'b0;
					if (pstrb_in[0] && pwdata_in[sdr_pkg::STS_BAD]) next_st.bad = 1'b0;
				end
				sdr_pkg::OFS_AF: begin
					w = merge({16'h0, st.a, st.f}, pwdata_in, pstrb_in);
					{next_st.a, next_st.f} = w[15:0];
				end
				sdr_pkg::OFS_BCDE: begin
					w = merge({st.b, st.c, st.d, st.e}, pwdata_in, pstrb_in);
					{next_st.b, next_st.c, next_st.d, next_st.e} = w;
				end
				sdr_pkg::OFS_HL: begin
					w = merge({16'h0, st.h, st.l}, pwdata_in, pstrb_in);
					{next_st.h, next_st.l} = w[15:0];
				end
				sdr_pkg::OFS_INDEX: begin
					w = merge({st.ix, st.iy}, pwdata_in, pstrb_in);
					{next_st.ix, next_st.iy} = w;
				end
				default: begin
					w = '0;
				end
			endcase
		end
		if (start) begin
			next_st.fsm  = sdr_pkg::ST_RUN;
			next_st.form = dec.form;
			next_st.op   = dec.op;
			next_st.mcyc = 3'h0;
			next_st.tcnt = 3'h0;
			next_st.tsum = 5'h0;
			if (dec.form == sdr_pkg::FM_IDX) begin
				next_st.mem_addr = ((wmerge[7:0] == sdr_pkg::PFX_IDX1) ? st.ix : st.iy)
					+ {{8{wmerge[23]}}, wmerge[23:16]};
			end else begin
				next_st.mem_addr = {st.h, st.l};
			end
		end
		if (run && tick) begin
			next_st.tsum = st.tsum + 5'h1;
			next_st.tcnt = st.tcnt + 3'h1;
		end
		if (m_end) begin
			next_st.tcnt = 3'h0;
			next_st.mcyc = st.mcyc + 3'h1;
			if (in_rd) begin
				next_st.opnd      = mem_rdata_in;
				next_st.mem_wdata = alu_res;
				next_st.a         = alu_acc;
				next_st.f         = alu_flags;
			end
			if (!mem_form && last_m) begin
				next_st.f = alu_flags;
				case (rcode)
					sdr_pkg::RC_B: next_st.b = alu_res;
					sdr_pkg::RC_C: next_st.c = alu_res;
					sdr_pkg::RC_D: next_st.d = alu_res;
					sdr_pkg::RC_E: next_st.e = alu_res;
					sdr_pkg::RC_H: next_st.h = alu_res;
					sdr_pkg::RC_L: next_st.l = alu_res;
					sdr_pkg::RC_A: next_st.a = alu_res;
					default:       next_st.a = st.a;
				endcase
			end
			if (last_m) begin
				// Completion after a software clear in the same cycle still sets done
				next_st.fsm  = sdr_pkg::ST_IDLE;
				next_st.mcyc = 3'h0;
				next_st.done = 1'b1;
			end
		end
	end

	always_ff @(posedge clock_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			st      <= '0;
			st.fsm  <= sdr_pkg::ST_IDLE;
			st.form <= sdr_pkg::FM_NONE;
			st.op   <= sdr_pkg::OP_ASR;
		end else begin
			st <= next_st;
		end
	end

	assign prdata_out    = st.prdata;
	assign pready_out    = psel_in && penable_in;
	assign pslverr_out   = psel_in && penable_in && st.pslverr;
	assign busy_out      = run;
	assign mem_out.addr  = st.mem_addr;
	assign mem_out.wdata = st.mem_wdata;
	assign mem_out.rd    = in_rd;
	assign mem_out.wr    = run && mem_form && st.mcyc == wr_idx;

	default clocking cb @(posedge clock_in); endclocking
	default disable iff (!arst_n_in);

	AST_ASR_SHIFT: assert property (
		run && st.op == sdr_pkg::OP_ASR |->
		alu_res == {alu_opnd[7], alu_opnd[7:1]} && alu_flags[sdr_pkg::FLG_C] == alu_opnd[0])
		else $error("arithmetic shift result or carry wrong");
	AST_ASR_SZ: assert property (
		m_end && in_rd && st.op == sdr_pkg::OP_ASR |=>
		st.f[sdr_pkg::FLG_S] == st.mem_wdata[7] && st.f[sdr_pkg::FLG_Z] == (st.mem_wdata == 8'h00))
		else $error("arithmetic shift sign or zero flag wrong");
	AST_LSR_TOP: assert property (
		run && st.op == sdr_pkg::OP_LSR |->
		!alu_res[7] && !alu_flags[sdr_pkg::FLG_S] && alu_flags[sdr_pkg::FLG_C] == alu_opnd[0])
		else $error("logical shift bit 7, sign or carry wrong");
	AST_SHIFT_PHN: assert property (
		run && (st.op == sdr_pkg::OP_ASR || st.op == sdr_pkg::OP_LSR) |->
		alu_flags[sdr_pkg::FLG_P] == ~^alu_res && !alu_flags[sdr_pkg::FLG_H]
		&& !alu_flags[sdr_pkg::FLG_N])
		else $error("shift parity, half carry or subtract wrong");
	AST_TIMING: assert property (
		m_end && last_m |-> st.tsum + 5'h1 == (st.form == sdr_pkg::FM_REG ? sdr_pkg::TT_REG :
		st.form == sdr_pkg::FM_PTR ? sdr_pkg::TT_PTR : st.form == sdr_pkg::FM_IDX ?
		sdr_pkg::TT_IDX : sdr_pkg::TT_DIG))
		else $error("instruction T-state total wrong");
	AST_DRL_MOVE: assert property (
		m_end && in_rd && st.op == sdr_pkg::OP_DRL |=>
		st.mem_wdata == {$past(mem_rdata_in[3:0]), $past(st.a[3:0])}
		&& st.a[3:0] == $past(mem_rdata_in[7:4]))
		else $error("left digit rotate nibbles wrong");
	AST_DRR_MOVE: assert property (
		m_end && in_rd && st.op == sdr_pkg::OP_DRR |=>
		st.mem_wdata == {$past(st.a[3:0]), $past(mem_rdata_in[7:4])}
		&& st.a[3:0] == $past(mem_rdata_in[3:0]))
		else $error("right digit rotate nibbles wrong");
	AST_ACC_HIGH: assert property (
		run && st.form == sdr_pkg::FM_DIG |=> $stable(st.a[7:4]))
		else $error("accumulator high nibble changed by rotate");
	AST_DIG_FLAGS: assert property (
		m_end && in_rd && st.form == sdr_pkg::FM_DIG |=>
		st.f[sdr_pkg::FLG_C] == $past(st.f[sdr_pkg::FLG_C]) && st.f[sdr_pkg::FLG_P] == ~^st.a
		&& st.f[sdr_pkg::FLG_Z] == (st.a == 8'h00) && !st.f[sdr_pkg::FLG_H])
		else $error("digit rotate flags wrong");
	// Rotates have already replaced the accumulator, so only operand nibbles are checked
	AST_WRITE_BACK: assert property (
		mem_out.wr |-> $stable(mem_out.addr) && (st.op == sdr_pkg::OP_DRL ?
		mem_out.wdata[7:4] == st.opnd[3:0] : st.op == sdr_pkg::OP_DRR ?
		mem_out.wdata[3:0] == st.opnd[7:4] : mem_out.wdata == alu_res))
		else $error("write back data or address wrong");
	AST_IDX_ADDR: assert property (
		mem_out.rd && st.form == sdr_pkg::FM_IDX |-> mem_out.addr ==
		((st.instr[7:0] == sdr_pkg::PFX_IDX1 ? st.ix : st.iy) + {{8{st.instr[23]}}, st.instr[23:16]}))
		else $error("indexed address wrong");
endmodule

// ---- bench/sdr_mem_model.sv ----
// Purpose: byte memory on the far side of the shift and digit rotate unit
// Assumes: read data is needed within the read machine cycle, no handshake
// Notes: outside a read the data lines show the inverse of the last byte read
`timescale 1ns/100ps
module sdr_mem_model (
	input  wire logic              clock_in,  // Core clock
	input  wire sdr_pkg::sdr_mem_s mem_in,    // Address, data, strobes
	output logic [7:0]             rdata_out  // Read byte
);
	logic [7:0] mem [0:65535];
	logic [7:0] last = 8'h00;
	// A late or early sample sees a wrong byte instead of a lucky stale one
	always_comb rdata_out = mem_in.rd ? mem[mem_in.addr] : ~last;
	always @(posedge clock_in) begin
		if (mem_in.rd)
			last <= mem[mem_in.addr];
		if (mem_in.wr)
			mem[mem_in.addr] <= mem_in.wdata;
	end
endmodule

// ---- bench/sdr_core_tb.sv ----
// Purpose: self-checking bench of the shift and digit rotate unit
// Assumes: one T-state per clock, memory answers at once
// Notes: expected results are worked out here from the bit movements
`timescale 1ns/100ps
`define CHK(nm, ex, gt) begin compares++; if ((gt) !== (ex)) begin n_fail++; \
	$display("ERROR %s exp %h got %h", nm, ex, gt); end end
module sdr_core_tb;
	logic              clock_in   = 1'b0;
	logic              arst_n_in  = 1'b0;
	logic              psel_in    = 1'b0;
	logic              penable_in = 1'b0;
	logic              pwrite_in  = 1'b0;
	logic [7:0]        paddr_in   = 8'h00;
	logic [31:0]       pwdata_in  = 32'h0;
	logic [31:0]       prdata_out;
	logic              pready_out;
	logic              pslverr_out;
	logic              busy_out;
	logic [7:0]        mem_rdata_in;
	sdr_pkg::sdr_mem_s mem_out;
	int                n_fail     = 0;
	int                compares   = 0;

	always #4 clock_in = ~clock_in;

	sdr_core #(.TSTATE_DIV(1)) u_sdr_core (.clock_in(clock_in), .arst_n_in(arst_n_in),
		.psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in),
		.paddr_in(paddr_in), .pwdata_in(pwdata_in), .pstrb_in(4'hf),
		.prdata_out(prdata_out), .pready_out(pready_out), .pslverr_out(pslverr_out),
		.mem_rdata_in(mem_rdata_in), .mem_out(mem_out), .busy_out(busy_out));
	sdr_mem_model u_sdr_mem_model (.clock_in(clock_in), .mem_in(mem_out),
		.rdata_out(mem_rdata_in));

	function automatic logic [7:0] flg(input logic [7:0] r, input logic c, input logic [7:0] f0);
		return {r[7], r == 8'h00, f0[5], 1'b0, f0[3], ~^r, 1'b0, c};
	endfunction

	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q, output logic err);
		int n;
		n = 0;
		@(posedge clock_in);
		psel_in <= 1'b1;
		pwrite_in <= w;
		paddr_in <= a;
		pwdata_in <= d;
		@(posedge clock_in);
		penable_in <= 1'b1;
		do begin
			@(posedge clock_in);
			n++;
		end while (pready_out !== 1'b1 && n < 50);
		`CHK("pready", 1'b1, pready_out)
		q = prdata_out;
		err = pslverr_out;
		psel_in <= 1'b0;
		penable_in <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		logic        e;
		apb(1'b1, a, d, q, e);
	endtask

	task automatic chk(input logic [7:0] a, input logic [31:0] exp, input string nm);
		logic [31:0] q;
		logic        e;
		apb(1'b0, a, 32'h0, q, e);
		`CHK(nm, exp, q)
	endtask

	// Busy is counted clock by clock, so the length of every form is pinned
	task automatic run(input logic [31:0] ins, input int exp);
		int n;
		n = 0;
		wr(sdr_pkg::OFS_INSTR, ins);
		#1;
		while (busy_out === 1'b1 && n < 100) begin
			@(posedge clock_in);
			#1;
			n++;
		end
		`CHK("busy clocks", exp, n)
	endtask

	task automatic t_shift_reg();
		logic [7:0] v [8];
		logic [7:0] e [8];
		logic [7:0] f0;
		logic [7:0] r;
		for (int k = 0; k < 2; k++) begin
			for (int rc = 0; rc < 8; rc++) begin
				if (rc == 6)
					continue;
				v = '{8'h01, 8'h80, 8'hb8, 8'h8f, 8'hff, 8'h02, 8'h00, 8'h7e};
				f0 = k ? 8'h00 : 8'hff;
				wr(sdr_pkg::OFS_BCDE, {v[0], v[1], v[2], v[3]});
				wr(sdr_pkg::OFS_HL, {16'h0, v[4], v[5]});
				wr(sdr_pkg::OFS_AF, {16'h0, v[7], f0});
				r = k ? {1'b0, v[rc][7:1]} : {v[rc][7], v[rc][7:1]};
				e = v;
				e[rc] = r;
				run({16'h0, (k ? 8'h38 : 8'h28) | 8'(rc), 8'hcb}, 8);
				chk(sdr_pkg::OFS_BCDE, {e[0], e[1], e[2], e[3]}, "bcde");
				chk(sdr_pkg::OFS_HL, {16'h0, e[4], e[5]}, "hl");
				chk(sdr_pkg::OFS_AF, {16'h0, e[7], flg(r, v[rc][0], f0)}, "af");
			end
		end
		$display("t_shift_reg done");
	endtask

	task automatic t_shift_mem();
		logic [31:0] ins [4] = '{32'h0000_2ecb, 32'h0000_3ecb, 32'h2e03_cbdd, 32'h3efe_cbfd};
		logic [15:0] ad [4] = '{16'h4343, 16'h4343, 16'h1003, 16'h1ffe};
		logic [7:0]  v;
		logic [7:0]  r;
		wr(sdr_pkg::OFS_HL, 32'h0000_4343);
		wr(sdr_pkg::OFS_INDEX, 32'h1000_2000);
		for (int i = 0; i < 4; i++) begin
			v = (i % 2) ? 8'h8f : 8'hb8;
			r = (i % 2) ? {1'b0, v[7:1]} : {v[7], v[7:1]};
			u_sdr_mem_model.mem[ad[i]] = v;
			wr(sdr_pkg::OFS_AF, 32'h0000_00ff);
			run(ins[i], i < 2 ? 15 : 23);
			`CHK("mem result", r, u_sdr_mem_model.mem[ad[i]])
			chk(sdr_pkg::OFS_AF, {24'h0, flg(r, v[0], 8'hff)}, "mem af");
		end
		$display("t_shift_mem done");
	endtask

	task automatic t_digit();
		logic [7:0] a;
		logic [7:0] m;
		logic [7:0] ea;
		logic [7:0] em;
		logic [7:0] f0;
		for (int i = 0; i < 2; i++) begin
			a = i ? 8'h84 : 8'h7a;
			m = i ? 8'h20 : 8'h31;
			f0 = i ? 8'h00 : 8'hff;
			u_sdr_mem_model.mem[16'h5000] = m;
			wr(sdr_pkg::OFS_HL, 32'h0000_5000);
			wr(sdr_pkg::OFS_AF, {16'h0, a, f0});
			ea = {a[7:4], i ? m[3:0] : m[7:4]};
			em = i ? {a[3:0], m[7:4]} : {m[3:0], a[3:0]};
			run({16'h0, i ? 8'h67 : 8'h6f, 8'hed}, 18);
			chk(sdr_pkg::OFS_AF, {16'h0, ea, flg(ea, f0[0], f0)}, "digit af");
			`CHK("digit mem", em, u_sdr_mem_model.mem[16'h5000])
		end
		$display("t_digit done");
	endtask

	// Done and bad flags, and a register write refused while an instruction runs
	task automatic t_status();
		logic [31:0] q;
		logic        e;
		chk(sdr_pkg::OFS_STATUS, 32'h0000_0002, "status done");
		wr(sdr_pkg::OFS_STATUS, 32'h0000_0006);
		wr(sdr_pkg::OFS_INSTR, 32'h0000_00ff);
		chk(sdr_pkg::OFS_STATUS, 32'h0000_0004, "status bad");
		wr(sdr_pkg::OFS_INSTR, 32'h0000_38cb);
		apb(1'b1, sdr_pkg::OFS_HL, 32'h0000_1234, q, e);
		`CHK("busy slverr", 1'b1, e)
		repeat (12) @(posedge clock_in);
		chk(sdr_pkg::OFS_STATUS, 32'h0000_0002, "status after run");
		chk(sdr_pkg::OFS_HL, 32'h0000_5000, "hl kept");
		$display("t_status done");
	endtask

	task automatic t_unmapped();
		logic [31:0] q;
		logic        e;
		apb(1'b0, 8'h18, 32'h0, q, e);
		`CHK("slverr", 1'b1, e)
		`CHK("unmapped rdata", 32'h0, q)
		$display("t_unmapped done");
	endtask

	task automatic test_done();
		$display("checks %0d failures %0d", compares, n_fail);
		if (n_fail == 0 && compares > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	initial begin
		repeat (16) @(posedge clock_in);
		arst_n_in <= 1'b1;
		t_shift_reg();
		t_shift_mem();
		t_digit();
		t_status();
		t_unmapped();
		test_done();
	end

	initial begin
		#200000;
		n_fail++;
		test_done();
	end
endmodule
